// [verilog/dsr_pkg.sv]
// Purpose: shared constants and carriers of the debug status register bank
// Assumes: one 32-bit word per register, byte addresses as decoded
// Notes: offsets, field positions and reset values live only here

package dsr_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [31:0] DSR_ADDR_HALT_CTRL = 32'he000_edf0;
  localparam logic [31:0] DSR_ADDR_CORE_SEL = 32'he000_edf4;
  localparam logic [31:0] DSR_ADDR_CORE_DATA = 32'he000_edf8;
  localparam logic [31:0] DSR_ADDR_MON_CTRL = 32'he000_edfc;
  localparam logic [31:0] DSR_ADDR_RSV_LO = 32'he000_ee00;
  localparam logic [31:0] DSR_ADDR_RSV_HI = 32'he000_eeff;
  localparam logic [31:0] DSR_ADDR_HANDLER = 32'he000_ed80;
  localparam logic [31:0] DSR_ADDR_FAULT = 32'he000_ed84;

  // ----------------------------------------------------------------
  // field layout and reset values
  // ----------------------------------------------------------------
  localparam int DSR_WORD_W = 32;
  localparam int DSR_FAULT_W = 5;
  localparam int DSR_SVC_BIT = 15;
  localparam int DSR_FS_HALTED = 0;
  localparam int DSR_FS_BREAKPOINT_EVENT_FLAG = 1;
  localparam int DSR_FS_WATCH = 2;
  localparam int DSR_FS_VECTOR_CATCH_FLAG = 3;
  localparam int DSR_FS_EXT = 4;
  localparam logic [31:0] DSR_WORD_RST = 32'h0000_0000;
  localparam logic [4:0] DSR_FAULT_RST = 5'h00;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic valid;
    logic write;
    logic [31:0] addr;
    logic [31:0] wdata;
  } dsr_req_s;

  typedef struct packed {
    logic ext_debug_request_in;
    logic vector_catch;
    logic watch_unit;
    logic breakpoint;
    logic halt_request;
    logic step_done;
  } dsr_evt_s;

  typedef struct packed {
    logic svc_occur;
    logic svc_active;
  } dsr_svc_s;

  typedef struct packed {
    logic [31:0] halt_ctrl;
    logic [31:0] core_sel;
    logic [31:0] core_data;
    logic [31:0] mon_ctrl;
    logic svc_pend;
    logic [4:0] fault;
    logic [31:0] rdata;
    logic ack;
  } dsr_state_s;

endpackage : dsr_pkg

// [verilog/dsr_bank.sv]
// Purpose: debug register bank reached from the debug access port
// Assumes: access requests and core events are synchronous to clk
// Notes: resetn is power-on reset; local_resetn spares the fault status
//
// Contract
// - every debug control block register is a full 32-bit word.
// - decode halting control, selector (write-only), core data, monitor control.
// - word range 0xE000EE00..0xE000EEFF stays reserved, no function.
// - handler, fault status and control block reachable through the access port.
// - handler register bit 15 reads pending state; a write sets or clears it from bit 15 of the data.
// - pending sets when the exception occurs, clears when it becomes active.
// - writing 1 to a fault status bit clears it; 0 leaves it.
// - power-on reset clears fault status; local reset leaves it alone.
// - fault bit 4 sets on an external debug request event.
// - fault bit 3 sets on a vector catch debug event.
// - fault bit 2 sets when the watchpoint unit makes an event.
// - fault bit 1 sets on any breakpoint debug event.
// - fault bit 0 sets while a halt request or step completion event is active.
// - completing a single step sets the halted bit.

`timescale 1ns/1ps
`default_nettype none

module dsr_bank (
  // clock and resets
  input wire logic clk,
  input wire logic resetn,
  input wire logic local_resetn,
  // debug access port
  input wire dsr_pkg::dsr_req_s acc,
  output logic acc_ack,
  output logic [31:0] acc_rdata,
  // debug events from the core
  input wire dsr_pkg::dsr_evt_s evt,
  input wire dsr_pkg::dsr_svc_s svc,
  // register contents toward the core
  output logic [31:0] halting_control_status,
  output logic [31:0] core_register_selector,
  output logic [31:0] core_register_data,
  output logic [31:0] exception_monitor_control,
  output logic supervisor_call_pending,
  output logic [4:0] debug_fault_status
);
  import dsr_pkg::*;

  dsr_state_s q;
  dsr_state_s d;
  logic rd;
  logic wr;
  logic in_rsv;
  logic [4:0] w1c;
  logic [4:0] fset;

  // ----------------------------------------------------------------
  // access decode
  // ----------------------------------------------------------------
  // only the access port reaches the bank; no core-side path exists
  assign rd = acc.valid && !acc.write;
  assign wr = acc.valid && acc.write;
  assign in_rsv = (acc.addr >= DSR_ADDR_RSV_LO) && (acc.addr <= DSR_ADDR_RSV_HI);

  // fault sources gathered by bit position
  always_comb begin
    fset = '0;
    fset[DSR_FS_EXT] = evt.ext_debug_request_in;
    fset[DSR_FS_VECTOR_CATCH_FLAG] = evt.vector_catch;
    fset[DSR_FS_WATCH] = evt.watch_unit;
    fset[DSR_FS_BREAKPOINT_EVENT_FLAG] = evt.breakpoint;
    fset[DSR_FS_HALTED] = evt.halt_request || evt.step_done;
  end

  // clear mask from a write to the fault status word
  assign w1c = (wr && acc.addr == DSR_ADDR_FAULT) ? acc.wdata[DSR_FAULT_W-1:0] : '0;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    d = q;
    d.ack = acc.valid;
    d.rdata = DSR_WORD_RST;
    // read mux; reserved window and unmapped words answer zero
    if (rd && !in_rsv) begin
      case (acc.addr)
        DSR_ADDR_HALT_CTRL: d.rdata = q.halt_ctrl;
        DSR_ADDR_CORE_SEL: d.rdata = DSR_WORD_RST;
        DSR_ADDR_CORE_DATA: d.rdata = q.core_data;
        DSR_ADDR_MON_CTRL: d.rdata = q.mon_ctrl;
        DSR_ADDR_HANDLER: d.rdata[DSR_SVC_BIT] = q.svc_pend;
        DSR_ADDR_FAULT: d.rdata[DSR_FAULT_W-1:0] = q.fault;
        default: d.rdata = DSR_WORD_RST;
      endcase
    end
    // full-word writes; reserved window swallows writes silently
    if (wr && !in_rsv) begin
      case (acc.addr)
        DSR_ADDR_HALT_CTRL: d.halt_ctrl = acc.wdata;
        DSR_ADDR_CORE_SEL: d.core_sel = acc.wdata;
        DSR_ADDR_CORE_DATA: d.core_data = acc.wdata;
        DSR_ADDR_MON_CTRL: d.mon_ctrl = acc.wdata;
        DSR_ADDR_HANDLER: d.svc_pend = acc.wdata[DSR_SVC_BIT];
        default: d.svc_pend = q.svc_pend;
      endcase
    end
    // exception taken clears pending, a new occurrence wins over activation and handler writes but not over local reset
    if (svc.svc_active) begin
      d.svc_pend = 1'b0;
    end
    if (svc.svc_occur) begin
      d.svc_pend = 1'b1;
    end
    // sticky faults: set beats a same-cycle write-one clear
    d.fault = (q.fault & ~w1c) | fset;
    // local reset spares the fault status word on purpose
    if (!local_resetn) begin
      d.halt_ctrl = DSR_WORD_RST;
      d.core_sel = DSR_WORD_RST;
      d.core_data = DSR_WORD_RST;
      d.mon_ctrl = DSR_WORD_RST;
      d.svc_pend = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  // power-on reset is the only reset that clears the fault word
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      q <= '{halt_ctrl: DSR_WORD_RST, core_sel: DSR_WORD_RST, core_data: DSR_WORD_RST,
             mon_ctrl: DSR_WORD_RST, svc_pend: 1'b0, fault: DSR_FAULT_RST,
             rdata: DSR_WORD_RST, ack: 1'b0};
    end else begin
      q <= d;
    end
  end

  // outputs straight from flip-flops
  assign acc_ack = q.ack;
  assign acc_rdata = q.rdata;
  assign halting_control_status = q.halt_ctrl;
  assign core_register_selector = q.core_sel;
  assign core_register_data = q.core_data;
  assign exception_monitor_control = q.mon_ctrl;
  assign supervisor_call_pending = q.svc_pend;
  assign debug_fault_status = q.fault;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  sequence s_read(logic [31:0] a);
    acc.valid && !acc.write && acc.addr == a;
  endsequence

  sequence s_write(logic [31:0] a);
    acc.valid && acc.write && acc.addr == a;
  endsequence

  sequence s_no_clear(int b);
    !(wr && acc.addr == DSR_ADDR_FAULT && acc.wdata[b]);
  endsequence

  AST_EXT_SETS: assert property (evt.ext_debug_request_in |=> debug_fault_status[DSR_FS_EXT])
    else $error("external request did not set fault bit 4");

  AST_VECTOR_CATCH_FLAG_SETS: assert property (evt.vector_catch |=> debug_fault_status[DSR_FS_VECTOR_CATCH_FLAG])
    else $error("vector catch did not set fault bit 3");

  AST_WATCH_SETS: assert property (evt.watch_unit |=> debug_fault_status[DSR_FS_WATCH])
    else $error("watch unit event did not set fault bit 2");

  AST_BREAKPOINT_EVENT_FLAG_HOLDS: assert property (evt.breakpoint ##1 (!evt.breakpoint ##0 s_no_clear(DSR_FS_BREAKPOINT_EVENT_FLAG))
      |=> debug_fault_status[DSR_FS_BREAKPOINT_EVENT_FLAG])
    else $error("breakpoint flag lost without a clear");

  AST_HALT_SETS: assert property ((evt.halt_request || evt.step_done) |=> debug_fault_status[DSR_FS_HALTED])
    else $error("halt or step event did not set fault bit 0");

  AST_W1C_CLEARS: assert property (s_write(DSR_ADDR_FAULT) ##0 (acc.wdata[DSR_FS_EXT] && !evt.ext_debug_request_in)
      |=> !debug_fault_status[DSR_FS_EXT])
    else $error("write one did not clear fault bit");

  // a same-cycle event may still set a bit, so only quiet cycles count
  AST_W0_KEEPS: assert property (s_write(DSR_ADDR_FAULT) ##0 (acc.wdata[DSR_FAULT_W-1:0] == '0 && fset == '0)
      |=> debug_fault_status == $past(debug_fault_status, 1))
    else $error("write zero changed fault status");

  AST_LOCAL_KEEPS: assert property (!local_resetn && fset == '0 && w1c == '0
      |=> debug_fault_status == $past(debug_fault_status))
    else $error("local reset disturbed fault status");

  AST_SVC_OCCUR: assert property (svc.svc_occur && local_resetn |=> supervisor_call_pending)
    else $error("pending not set on exception");

  AST_SVC_ACTIVE: assert property (svc.svc_active && !svc.svc_occur && local_resetn
      |=> !supervisor_call_pending)
    else $error("pending not cleared on activation");

  AST_SVC_READ: assert property (s_read(DSR_ADDR_HANDLER)
      |=> acc_ack && acc_rdata == ({31'h0000_0000, $past(supervisor_call_pending)} << DSR_SVC_BIT))
    else $error("handler word read wrong");

  AST_SVC_WRITE: assert property (s_write(DSR_ADDR_HANDLER) ##0 (!svc.svc_occur && !svc.svc_active && local_resetn)
      |=> supervisor_call_pending == $past(acc.wdata[DSR_SVC_BIT]))
    else $error("handler write did not update pending");

  AST_RSV_ZERO: assert property (rd && in_rsv |=> acc_ack && acc_rdata == DSR_WORD_RST)
    else $error("reserved window read not zero");

  AST_SEL_WO: assert property (s_read(DSR_ADDR_CORE_SEL) |=> acc_rdata == DSR_WORD_RST)
    else $error("selector readable");

  AST_WORD_RW: assert property (s_write(DSR_ADDR_MON_CTRL) ##0 local_resetn ##1 s_read(DSR_ADDR_MON_CTRL)
      |=> acc_rdata == $past(acc.wdata, 2))
    else $error("monitor control word did not read back");

  // ----------------------------------------------------------------
  // access handshake and full-word storage
  // ----------------------------------------------------------------
  // every request is answered exactly one edge later, never otherwise
  AST_ACK_NEXT: assert property (acc.valid |=> acc_ack)
    else $error("request not acknowledged");

  AST_ACK_IDLE: assert property (!acc.valid |=> !acc_ack)
    else $error("acknowledge without request");

  AST_RD_IDLE_ZERO: assert property (!acc.valid |=> acc_rdata == DSR_WORD_RST)
    else $error("read data not zero when idle");

  AST_WR_RDATA_ZERO: assert property (wr |=> acc_rdata == DSR_WORD_RST)
    else $error("write returned read data");

  AST_HALT_WR: assert property (s_write(DSR_ADDR_HALT_CTRL) ##0 local_resetn
      |=> halting_control_status == $past(acc.wdata))
    else $error("halting control write lost");

  AST_SEL_WR: assert property (s_write(DSR_ADDR_CORE_SEL) ##0 local_resetn
      |=> core_register_selector == $past(acc.wdata))
    else $error("selector write lost");

  AST_DATA_WR: assert property (s_write(DSR_ADDR_CORE_DATA) ##0 local_resetn
      |=> core_register_data == $past(acc.wdata))
    else $error("core data write lost");

  AST_MON_WR: assert property (s_write(DSR_ADDR_MON_CTRL) ##0 local_resetn
      |=> exception_monitor_control == $past(acc.wdata))
    else $error("monitor control write lost");

  // local reset clears the control words but never the fault word
  AST_LOCAL_CLEARS: assert property (!local_resetn
      |=> halting_control_status == DSR_WORD_RST && core_register_selector == DSR_WORD_RST
          && core_register_data == DSR_WORD_RST && exception_monitor_control == DSR_WORD_RST
          && !supervisor_call_pending)
    else $error("local reset left a control word");

  // reserved window must not alias onto any stored word
  AST_RSV_NO_WRITE: assert property (wr && in_rsv && local_resetn && !svc.svc_occur && !svc.svc_active
      |=> $stable(halting_control_status) && $stable(core_register_selector)
          && $stable(core_register_data) && $stable(exception_monitor_control)
          && $stable(supervisor_call_pending))
    else $error("reserved write changed a register");

  // ----------------------------------------------------------------
  // reserved bits and remaining event sources
  // ----------------------------------------------------------------
  AST_FAULT_READ: assert property (s_read(DSR_ADDR_FAULT)
      |=> acc_rdata == {27'h000_0000, $past(debug_fault_status)})
    else $error("fault word read wrong");

  AST_HANDLER_RSV: assert property (s_read(DSR_ADDR_HANDLER)
      |=> (acc_rdata & ~(32'h0000_0001 << DSR_SVC_BIT)) == DSR_WORD_RST)
    else $error("handler reserved bits not zero");

  AST_BREAKPOINT_EVENT_FLAG_SETS: assert property (evt.breakpoint |=> debug_fault_status[DSR_FS_BREAKPOINT_EVENT_FLAG])
    else $error("breakpoint did not set fault bit 1");

  AST_STEP_SETS: assert property (evt.step_done |=> debug_fault_status[DSR_FS_HALTED])
    else $error("step completion did not set halted bit");

  // activation outranks a plain handler write in the same cycle
  AST_SVC_ACT_WINS: assert property (s_write(DSR_ADDR_HANDLER) ##0 (svc.svc_active && !svc.svc_occur)
      |=> !supervisor_call_pending)
    else $error("handler write beat activation");

  // ----------------------------------------------------------------
  // stickiness: a set bit only leaves through a write of one
  // ----------------------------------------------------------------
  AST_EXT_HOLDS: assert property (debug_fault_status[DSR_FS_EXT] ##0 s_no_clear(DSR_FS_EXT)
      |=> debug_fault_status[DSR_FS_EXT])
    else $error("external flag lost without a clear");

  AST_VECTOR_CATCH_FLAG_HOLDS: assert property (debug_fault_status[DSR_FS_VECTOR_CATCH_FLAG] ##0 s_no_clear(DSR_FS_VECTOR_CATCH_FLAG)
      |=> debug_fault_status[DSR_FS_VECTOR_CATCH_FLAG])
    else $error("vector catch flag lost without a clear");

  AST_WATCH_HOLDS: assert property (debug_fault_status[DSR_FS_WATCH] ##0 s_no_clear(DSR_FS_WATCH)
      |=> debug_fault_status[DSR_FS_WATCH])
    else $error("watch flag lost without a clear");

  AST_HALTED_HOLDS: assert property (debug_fault_status[DSR_FS_HALTED] ##0 s_no_clear(DSR_FS_HALTED)
      |=> debug_fault_status[DSR_FS_HALTED])
    else $error("halted flag lost without a clear");

endmodule : dsr_bank

`default_nettype wire

// [verif/dsr_dbg_model.sv]
// Purpose: debugger model on the debug access port
// Assumes: bank answers one edge after the taking edge
// Notes: idle bus shows inverted last values, never stale ones
`timescale 1ns/1ps
`default_nettype none
module dsr_dbg_model (
  // clock
  input wire logic clk,
  // access port
  output var dsr_pkg::dsr_req_s acc,
  input wire logic acc_ack,
  input wire logic [31:0] acc_rdata
);
  import dsr_pkg::*;
  // quiet bus until the first access
  initial acc = '0;
  // one whole word; request held across its taking edge only
  // ack stands one cycle, so it is taken before the request is dropped
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic ok);
    @(negedge clk);
    acc = '{valid: 1'b1, write: w, addr: a, wdata: d};
    @(negedge clk);
    ok = acc_ack;
    q = acc_rdata;
    acc = '{valid: 1'b0, write: ~w, addr: ~a, wdata: ~d};
  endtask : xfer
  // write then read of one word on back-to-back edges
  task automatic xfer_wr_rd(input logic [31:0] a, input logic [31:0] d,
                            output logic [31:0] q, output logic ok);
    @(negedge clk);
    acc = '{valid: 1'b1, write: 1'b1, addr: a, wdata: d};
    @(negedge clk);
    ok = acc_ack;
    acc = '{valid: 1'b1, write: 1'b0, addr: a, wdata: ~d};
    @(negedge clk);
    ok = ok & acc_ack;
    q = acc_rdata;
    acc = '{valid: 1'b0, write: 1'b1, addr: ~a, wdata: d};
  endtask : xfer_wr_rd
endmodule : dsr_dbg_model
`default_nettype wire

// [verif/dsr_bank_tb.sv]
// Purpose: self-checking bench of the debug register bank
// Assumes: inputs change at the falling edge, seed 69
// Notes: expected values come from the bench itself, never from the DUT
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin mismatches++; \
  $display("[FAIL] t=%0t got %h exp %h", $time, a, b); end end
module dsr_bank_tb;
  import dsr_pkg::*;
  logic clk, resetn, local_resetn, acc_ack, svp, ok;
  dsr_req_s acc;
  dsr_evt_s evt;
  dsr_svc_s svc;
  logic [31:0] acc_rdata, hc, cs, cd, mc, q, d;
  logic [4:0] dfs;
  int mismatches, num_checks, seed, i;
  localparam logic [31:0] RWA [3] = '{DSR_ADDR_HALT_CTRL, DSR_ADDR_CORE_DATA, DSR_ADDR_MON_CTRL};
  localparam logic [31:0] RSV [3] = '{DSR_ADDR_RSV_LO, DSR_ADDR_RSV_HI, 32'he000_ed00};
  dsr_bank DUT (.clk(clk), .resetn(resetn), .local_resetn(local_resetn), .acc(acc),
    .acc_ack(acc_ack), .acc_rdata(acc_rdata), .evt(evt), .svc(svc),
    .halting_control_status(hc), .core_register_selector(cs), .core_register_data(cd),
    .exception_monitor_control(mc), .supervisor_call_pending(svp), .debug_fault_status(dfs));
  dsr_dbg_model dbg (.clk(clk), .acc(acc), .acc_ack(acc_ack), .acc_rdata(acc_rdata));
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // step_done shares the halted flag with halt_request
  function automatic logic [4:0] fbit(input int k);
    return (k == 0) ? 5'h01 : 5'(1 << (k - 1));
  endfunction : fbit
  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    dbg.xfer(1'b0, a, 32'h0000_0000, q, ok);
    `CHK({ok, q}, {1'b1, e})
  endtask : rd
  task automatic wr(input logic [31:0] a, input logic [31:0] v);
    dbg.xfer(1'b1, a, v, q, ok);
    `CHK({ok, q}, {1'b1, 32'h0000_0000})
  endtask : wr
  task automatic pulse_evt(input logic [5:0] e);
    @(negedge clk);
    evt = e;
    @(negedge clk);
    evt = '0;
  endtask : pulse_evt
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : finish_test
  // free-running 25 MHz clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // hang guard, far beyond the roughly 115 cycles used
  initial begin
    #(40 * 5000);
    mismatches++;
    finish_test();
  end
  // main sequence
  initial begin
    seed = 69;
    resetn = 1'b0;
    local_resetn = 1'b1;
    evt = '0;
    svc = '0;
    repeat (12) @(negedge clk);
    resetn = 1'b1;
    // storage words and random traffic
    foreach (RWA[k]) begin
      rd(RWA[k], 32'h0000_0000);
      d = $random(seed);
      wr(RWA[k], d);
      rd(RWA[k], d);
    end
    d = $random(seed);
    dbg.xfer_wr_rd(DSR_ADDR_MON_CTRL, d, q, ok);
    `CHK({ok, q}, {1'b1, d})
    d = $random(seed);
    wr(DSR_ADDR_CORE_SEL, d);
    `CHK(cs, d)
    rd(DSR_ADDR_CORE_SEL, 32'h0000_0000);
    // reserved window and a hole: writes vanish
    foreach (RSV[k]) begin
      wr(RSV[k], $random(seed));
      rd(RSV[k], 32'h0000_0000);
    end
    // pending bit by write, then by exception flow
    wr(DSR_ADDR_HANDLER, 32'hffff_ffff);
    rd(DSR_ADDR_HANDLER, 32'h0000_8000);
    wr(DSR_ADDR_HANDLER, 32'h7fff_7fff);
    `CHK(svp, 1'b0)
    @(negedge clk) svc.svc_occur = 1'b1;
    @(negedge clk) svc = '0;
    `CHK(svp, 1'b1)
    @(negedge clk) svc.svc_active = 1'b1;
    @(negedge clk) svc = '0;
    `CHK(svp, 1'b0)
    // every event source, sticky until written one
    for (i = 0; i < 6; i++) begin
      pulse_evt(6'(1 << i));
      `CHK(dfs, fbit(i))
      wr(DSR_ADDR_FAULT, $random(seed) & ~{27'h0, fbit(i)});
      rd(DSR_ADDR_FAULT, {27'h0, fbit(i)});
      wr(DSR_ADDR_FAULT, {27'h0, fbit(i)});
      `CHK(dfs, 5'h00)
    end
    // local reset spares faults, power-on clears them
    pulse_evt(6'h3f);
    wr(DSR_ADDR_MON_CTRL, $random(seed));
    @(negedge clk) local_resetn = 1'b0;
    @(negedge clk) local_resetn = 1'b1;
    `CHK({dfs, mc}, {5'h1f, 32'h0000_0000})
    @(negedge clk) resetn = 1'b0;
    @(negedge clk) resetn = 1'b1;
    `CHK(dfs, 5'h00)
    finish_test();
  end
endmodule : dsr_bank_tb
`default_nettype wire
